//--- test/serial_controller_model.sv
// Behavioural system controller that drives the three-wire serial link.
// Assumes the device shifts on the rising serial clock and updates readback there.
`timescale 1ns/1ns
module serial_controller_model (
  output logic      serial_clock_in,
  output logic      chip_enable,
  output logic      serial_write_line,
  input  wire logic serial_read_line
);
  initial begin
    serial_clock_in   = 1'b0;
    chip_enable       = 1'b0;
    serial_write_line = 1'b0;
  end

  // ----------------------------------------------------------------
  // One bit, 48 ns clock period, clock idles low
  // ----------------------------------------------------------------
  task automatic clk_bit(input logic d, output logic q);
    serial_write_line = d;
    #24 serial_clock_in = 1'b1;
    #20 q = serial_read_line;
    #4 serial_clock_in = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Address with enable low, then data bits with enable high
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] addr, input int nbits, input logic [23:0] wd,
                       output logic [31:0] rd);
    logic q;
    rd = '0;
    chip_enable = 1'b0;
    for (int i = 0; i < 8; i++) begin
      clk_bit(addr[i], q);
    end
    #24 chip_enable = 1'b1;
    #120;
    for (int i = 0; i < nbits; i++) begin
      clk_bit(wd[i % 24], q);
      rd = {rd[30:0], q};
    end
    #24 chip_enable = 1'b0;
    serial_write_line = ~serial_write_line;
    #200;
  endtask
endmodule

//--- test/tuner_serial_port_control_tb_top.sv
// Self-checking bench for the tuner serial port control block.
// Assumes the serial controller model and the tuner package are compiled first.
`timescale 1ns/1ns
module tuner_serial_port_control_tb_top;
  import tuner_pkg::*;
  localparam int G [4] = '{20, 40, 80, 160};
  logic        pclk, presetn, if_count_input, div_pulse_in, ref_pulse_in, pready, pslverr;
  logic        serial_clock_in, chip_enable, serial_write_line, serial_read_line, err;
  logic        phase_compare_out, phase_compare_oe;
  apb_req_t    apb;
  logic [31:0] prdata, rd, q, seed;
  logic [23:0] w;
  logic [3:0]  dedicated_out, dedicated_oe;
  logic [1:0]  dual_port_in, dual_port_out, dual_port_oe, dual_ext;
  int          fails, total_checks, cycles, if_run, hi, n;

  assign dual_port_in = dual_ext & ~dual_port_oe;

  tuner_serial_port_control #(.TB_HALF(8), .GATE0(G[0]), .GATE1(G[1]), .GATE2(G[2]),
    .GATE3(G[3])) uut (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_in(serial_clock_in),
    .chip_enable(chip_enable), .serial_write_line(serial_write_line),
    .serial_read_line(serial_read_line), .dedicated_out(dedicated_out),
    .dedicated_oe(dedicated_oe), .dual_port_in(dual_port_in), .dual_port_out(dual_port_out),
    .dual_port_oe(dual_port_oe), .if_count_input(if_count_input),
    .div_pulse_in(div_pulse_in), .ref_pulse_in(ref_pulse_in),
    .phase_compare_out(phase_compare_out), .phase_compare_oe(phase_compare_oe));

  serial_controller_model ctl (.serial_clock_in(serial_clock_in), .chip_enable(chip_enable),
    .serial_write_line(serial_write_line), .serial_read_line(serial_read_line));

  // ----------------------------------------------------------------
  // Clock, IF source, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n <= (n == 4) ? 0 : n + 1;
    if (if_run != 0 && n == 4) if_count_input <= ~if_count_input;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    apb.psel <= 1'b1;
    apb.pwrite <= wr;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge pclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fails++;
    q = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] a, input int nb, input logic [23:0] d);
    ctl.frame(a, nb, d, rd);
    repeat (10) @(posedge pclk);
  endtask
  task automatic pulse(input logic which);
    @(posedge pclk);
    if (which) div_pulse_in <= 1'b1;
    else ref_pulse_in <= 1'b1;
    @(posedge pclk);
    div_pulse_in <= 1'b0;
    ref_pulse_in <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic near(input logic [19:0] v, input int e);
    return (int'(v) >= e - 1) && (int'(v) <= e + 1);
  endfunction
  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h8D5E;
    {fails, total_checks, cycles, if_run, n} = '0;
    {if_count_input, div_pulse_in, ref_pulse_in} = 3'b000;
    apb = '0;
    dual_ext = 2'b11;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("ded oe reset", 32'h0, 32'(dedicated_oe));
    check("dual oe reset", 32'h0, 32'(dual_port_oe));
    $display("Test reset done");
    for (int k = 0; k < 8; k++) begin
      w = 24'($random(seed));
      w[14] = 1'b0;
      w[4] = 1'b0;
      if (k == 0) w[8:0] = 9'h1EF;
      send(ADDR_WRITE_A, 24 + k % 3, w);
      check("ded oe", 32'(w[3:0]), 32'(dedicated_oe));
      check("dual oe", 32'(w[6:5] & w[8:7]), 32'(dual_port_oe));
      check("pin values", 32'h0, 32'({dedicated_out, dual_port_out}));
      apb_xfer(1'b0, REG_CTRL_A, 32'h0);
      check("ctrl a", 32'(w), q);
      send(ADDR_WRITE_A, 23, ~w);
      send(ADDR_WRITE_B, 24, ~w);
      check("kept", 32'({w[3:0], w[6:5] & w[8:7]}), 32'({dedicated_oe, dual_port_oe}));
      apb_xfer(1'b0, REG_CTRL_B, 32'h0);
      check("ctrl b", 32'(w ^ 24'hFFFFFF), q);
    end
    apb_xfer(1'b1, REG_CTRL_A, 32'h0);
    apb_xfer(1'b0, REG_CTRL_A, 32'h0);
    check("ctrl a read only", 32'(w), q);
    apb_xfer(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h1, 32'(err));
    $display("Test writes done");
    for (int k = 0; k < 6; k++) begin
      w = 24'h000200 | (24'($random(seed)) & 24'h000060);
      dual_ext <= 2'($random(seed));
      send(ADDR_WRITE_A, 24, w);
      ctl.frame(ADDR_READ, 26, 24'h0, rd);
      check("readback levels", {6'h0, dual_ext & ~w[6:5], 24'h0}, rd);
    end
    $display("Test levels done");
    if_run = 1;
    for (int g = 0; g < 4; g++) begin
      send(ADDR_WRITE_A, 24, 24'h004000 | 24'(g << 12));
      hi = 0;
      do begin
        apb_xfer(1'b0, REG_IF, 32'h0);
        hi++;
      end while (q[30] !== 1'b1 && hi < 60);
      check("if gate count", 32'h1, 32'(near(q[19:0], G[g] / 10)));
      ctl.frame(ADDR_READ, 24, 24'h0, rd);
      check("if readback", 32'h1, 32'(near(rd[21:2], G[g] / 10) && rd[1:0] == 2'b01));
    end
    apb_xfer(1'b1, REG_IF_CMD, 32'h00000001);
    check("cmd err", 32'h0, 32'(err));
    apb_xfer(1'b0, REG_IF, 32'h0);
    check("if started", 32'h2, 32'(q[31:30]));
    hi = 0;
    do begin
      apb_xfer(1'b0, REG_IF, 32'h0);
      hi++;
    end while (q[30] !== 1'b1 && hi < 60);
    check("if cmd count", 32'h1, 32'(near(q[19:0], G[3] / 10)));
    if_run = 0;
    $display("Test counter done");
    send(ADDR_WRITE_A, 24, 24'h000010);
    hi = 0;
    for (int k = 0; k < 64; k++) begin
      @(negedge pclk);
      if (dedicated_oe[0] === 1'b1) hi++;
    end
    check("time base duty", 32'd32, 32'(hi));
    $display("Test time base done");
    pulse(1'b1);
    check("phase up", 32'h3, 32'({phase_compare_oe, phase_compare_out}));
    pulse(1'b0);
    check("phase match", 32'h0, 32'(phase_compare_oe));
    pulse(1'b0);
    check("phase down", 32'h2, 32'({phase_compare_oe, phase_compare_out}));
    pulse(1'b1);
    check("phase match", 32'h0, 32'(phase_compare_oe));
    $display("Test phase done");
    close_out();
  end
endmodule

//--- verilog/tuner_pkg.sv
// Constants, types and state carriers for the tuner serial port control block.
// Assumes a 50 MHz pclk and a serial clock driven by the system controller.
package tuner_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W         = 8;
  localparam int WORD_W         = 24;
  localparam int IFR_W          = 20;
  localparam int CNT_W          = 22;
  localparam int CLK_HZ         = 50_000_000;
  localparam int TB_HZ          = 8;
  localparam int TB_HALF_CYCLES = CLK_HZ / (2 * TB_HZ);
  localparam int GATE0_MS       = 4;
  localparam int GATE1_MS       = 8;
  localparam int GATE2_MS       = 32;
  localparam int GATE3_MS       = 64;
  localparam int GATE0_CYCLES   = CLK_HZ / 1000 * GATE0_MS;
  localparam int GATE1_CYCLES   = CLK_HZ / 1000 * GATE1_MS;
  localparam int GATE2_CYCLES   = CLK_HZ / 1000 * GATE2_MS;
  localparam int GATE3_CYCLES   = CLK_HZ / 1000 * GATE3_MS;

  // ----------------------------------------------------------------
  // Serial addresses, held as {A3..A0, B3..B0} after B0-first shifting
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WRITE_A = 8'h28;
  localparam logic [7:0] ADDR_WRITE_B = 8'h29;
  localparam logic [7:0] ADDR_READ    = 8'h2A;

  // ----------------------------------------------------------------
  // Control word fields and reset value
  // ----------------------------------------------------------------
  localparam int F_DED  = 0;
  localparam int F_TB   = 4;
  localparam int F_DIR  = 5;
  localparam int F_DOUT = 7;
  localparam int F_RSEL = 9;
  localparam int F_GATE = 12;
  localparam int F_IFST = 14;
  localparam logic [WORD_W-1:0] CTRL_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_A = 8'h00;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_IF     = 8'h08;
  localparam logic [7:0] REG_IF_CMD = 8'h0C;

  typedef enum logic [1:0] {MODE_NONE, MODE_WRITE_A, MODE_WRITE_B, MODE_READ} link_mode_t;
  typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DOWN} pfd_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        abits;
    link_mode_t        mode;
    logic              mode_valid;
    logic [4:0]        dbits;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] held_word;
    logic              held_b;
    logic              wr_toggle;
    logic [WORD_W-1:0] rb_shift;
    logic              dout;
  } link_state_t;

  typedef struct packed {
    logic              ce_s1, ce_s2, tog_s1, tog_s2, tog_seen;
    logic              pending, pend_b;
    logic [WORD_W-1:0] pend_word;
    logic [1:0]        dual_s1, dual_s2;
    logic              if_count_input_s1, if_count_input_s2, if_count_input_s3;
    logic              div_s1, div_s2, div_s3;
    logic              ref_s1, ref_s2, ref_s3;
    logic [WORD_W-1:0] ctrl_a, ctrl_b;
    logic              applied;
    logic [CNT_W-1:0]  tb_cnt;
    logic              tb_level;
    logic [CNT_W-1:0]  gate_cnt;
    logic [IFR_W-1:0]  if_cnt, if_result;
    logic              if_busy, if_done;
    pfd_state_t        pfd;
    logic [3:0]        ded_oe;
    logic [1:0]        dual_oe;
    logic              pc_out, pc_oe, od_level;
    logic [WORD_W-1:0] snap;
    logic              pready, pslverr;
    logic [31:0]       prdata;
  } core_state_t;

  // Maps a received address onto a transfer mode
  function automatic link_mode_t decode_mode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_WRITE_A) begin
      return MODE_WRITE_A;
    end else if (a == ADDR_WRITE_B) begin
      return MODE_WRITE_B;
    end else if (a == ADDR_READ) begin
      return MODE_READ;
    end
    return MODE_NONE;
  endfunction

endpackage

//--- verilog/tuner_serial_port_control.sv
// Serial control port, port pins, phase output and IF counter of a PLL tuner.
// Assumes an APB master on pclk and a controller driving the serial clock.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
module tuner_serial_port_control
  import tuner_pkg::*;
#(
  parameter int TB_HALF = TB_HALF_CYCLES,
  parameter int GATE0   = GATE0_CYCLES,
  parameter int GATE1   = GATE1_CYCLES,
  parameter int GATE2   = GATE2_CYCLES,
  parameter int GATE3   = GATE3_CYCLES
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire tuner_pkg::apb_req_t        apb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       serial_clock_in,
  input  wire logic                       chip_enable,
  input  wire logic                       serial_write_line,
  output logic                            serial_read_line,
  output logic [3:0]                      dedicated_out,
  output logic [3:0]                      dedicated_oe,
  input  wire logic [1:0]                 dual_port_in,
  output logic [1:0]                      dual_port_out,
  output logic [1:0]                      dual_port_oe,
  input  wire logic                       if_count_input,
  input  wire logic                       div_pulse_in,
  input  wire logic                       ref_pulse_in,
  output logic                            phase_compare_out,
  output logic                            phase_compare_oe
);
  import tuner_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (TB_HALF < 2 || TB_HALF >= (1 << CNT_W)) begin : g_bad_tb
    $error("TB_HALF out of range");
  end
  if (GATE0 < 2 || GATE1 < 2 || GATE2 < 2 || GATE3 < 2 ||
      GATE3 >= (1 << CNT_W)) begin : g_bad_gate
    $error("gate length out of range");
  end

  // Gate length for a select code
  function automatic logic [CNT_W-1:0] gate_cycles(input logic [1:0] sel);
    case (sel)
      2'd0:    return CNT_W'(GATE0);
      2'd1:    return CNT_W'(GATE1);
      2'd2:    return CNT_W'(GATE2);
      default: return CNT_W'(GATE3);
    endcase
  endfunction

  // Readback word for a content select code
  function automatic logic [WORD_W-1:0] content_word(input logic [2:0] sel,
                                                     input logic [1:0] lvl,
                                                     input logic [IFR_W-1:0] res,
                                                     input logic busy,
                                                     input logic done);
    case (sel)
      3'd0:    return {lvl, res, busy, done};
      3'd1:    return {lvl, 22'h000000};
      default: return {lvl, 20'h00000, busy, done};
    endcase
  endfunction

  // Known APB offsets
  function automatic logic reg_known(input logic [7:0] a);
    return (a == REG_CTRL_A) || (a == REG_CTRL_B) || (a == REG_IF) || (a == REG_IF_CMD);
  endfunction

  link_state_t l, next_l;
  core_state_t c, next_c;

  // ----------------------------------------------------------------
  // Link domain: address, mode, write and readback shifting
  // ----------------------------------------------------------------
  always_comb begin
    next_l = l;
    if (!chip_enable) begin
      next_l.addr       = {serial_write_line, l.addr[ADDR_W-1:1]};
      next_l.abits      = (l.abits == 4'd8) ? l.abits : l.abits + 4'd1;
      next_l.mode_valid = 1'b0;
      next_l.dbits      = 5'd0;
    end else begin
      if (!l.mode_valid) begin
        next_l.mode_valid = 1'b1;
        next_l.mode       = (l.abits == 4'd8) ? decode_mode(l.addr) : MODE_NONE;
      end
      case (next_l.mode)
        MODE_WRITE_A, MODE_WRITE_B: begin
          if (l.dbits != 5'd24) begin
            next_l.dbits = l.dbits + 5'd1;
            next_l.word  = {serial_write_line, l.word[WORD_W-1:1]};
          end
          if (l.dbits == 5'd23) begin
            next_l.held_word = next_l.word;
            next_l.held_b    = (next_l.mode == MODE_WRITE_B);
            next_l.wr_toggle = !l.wr_toggle;
          end
        end
        MODE_READ: begin
          if (!l.mode_valid) begin
            next_l.dout     = c.snap[WORD_W-1];
            next_l.rb_shift = {c.snap[WORD_W-2:0], 1'b0};
          end else begin
            next_l.dout     = l.rb_shift[WORD_W-1];
            next_l.rb_shift = {l.rb_shift[WORD_W-2:0], 1'b0};
          end
        end
        default: begin
          next_l.dout = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge serial_clock_in or negedge presetn) begin
    if (!presetn) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  logic start;
  logic if_edge;
  logic div_edge;
  logic ref_edge;

  always_comb begin
    next_c   = c;
    start    = 1'b0;
    if_edge  = c.if_count_input_s2 && !c.if_count_input_s3;
    div_edge = c.div_s2 && !c.div_s3;
    ref_edge = c.ref_s2 && !c.ref_s3;
    next_c.ce_s1   = chip_enable;
    next_c.ce_s2   = c.ce_s1;
    next_c.tog_s1  = l.wr_toggle;
    next_c.tog_s2  = c.tog_s1;
    next_c.dual_s1 = dual_port_in;
    next_c.dual_s2 = c.dual_s1;
    next_c.if_count_input_s1 = if_count_input;
    next_c.if_count_input_s2 = c.if_count_input_s1;
    next_c.if_count_input_s3 = c.if_count_input_s2;
    next_c.div_s1  = div_pulse_in;
    next_c.div_s2  = c.div_s1;
    next_c.div_s3  = c.div_s2;
    next_c.ref_s1  = ref_pulse_in;
    next_c.ref_s2  = c.ref_s1;
    next_c.ref_s3  = c.ref_s2;
    // Completed words wait for enable to fall
    if (c.tog_s2 != c.tog_seen) begin
      next_c.tog_seen  = c.tog_s2;
      next_c.pending   = 1'b1;
      next_c.pend_b    = l.held_b;
      next_c.pend_word = l.held_word;
    end else if (c.pending && !c.ce_s2) begin
      next_c.pending = 1'b0;
      if (c.pend_b) begin
        next_c.ctrl_b = c.pend_word;
      end else begin
        next_c.ctrl_a  = c.pend_word;
        next_c.applied = 1'b1;
        start          = c.pend_word[F_IFST];
      end
    end
    // APB slave, one wait state
    next_c.pready  = 1'b0;
    next_c.pslverr = 1'b0;
    if (apb.psel && apb.penable && !c.pready) begin
      next_c.pready  = 1'b1;
      next_c.pslverr = !reg_known(apb.paddr);
      next_c.prdata  = 32'h00000000;
      if (!apb.pwrite) begin
        if (apb.paddr == REG_CTRL_A) begin
          next_c.prdata = {8'h00, c.ctrl_a};
        end else if (apb.paddr == REG_CTRL_B) begin
          next_c.prdata = {8'h00, c.ctrl_b};
        end else if (apb.paddr == REG_IF) begin
          next_c.prdata = {c.if_busy, c.if_done, 10'h000, c.if_result};
        end
      end
    end
    if (apb.psel && apb.penable && c.pready && apb.pwrite && apb.paddr == REG_IF_CMD) begin
      start = start | apb.pwdata[0];
    end
    // IF counter
    if (start) begin
      next_c.if_busy  = 1'b1;
      next_c.if_done  = 1'b0;
      next_c.if_cnt   = '0;
      next_c.gate_cnt = gate_cycles(next_c.ctrl_a[F_GATE +: 2]) - CNT_W'(1);
    end else if (c.if_busy) begin
      next_c.if_cnt = c.if_cnt + IFR_W'(if_edge);
      if (c.gate_cnt == '0) begin
        next_c.if_busy   = 1'b0;
        next_c.if_done   = 1'b1;
        next_c.if_result = next_c.if_cnt;
      end else begin
        next_c.gate_cnt = c.gate_cnt - CNT_W'(1);
      end
    end
    // Time base
    if (c.tb_cnt == CNT_W'(TB_HALF - 1)) begin
      next_c.tb_cnt   = '0;
      next_c.tb_level = !c.tb_level;
    end else begin
      next_c.tb_cnt = c.tb_cnt + CNT_W'(1);
    end
    // Phase detector
    if (div_edge && ref_edge) begin
      next_c.pfd = PFD_IDLE;
    end else if (div_edge) begin
      next_c.pfd = (c.pfd == PFD_DOWN) ? PFD_IDLE : PFD_UP;
    end else if (ref_edge) begin
      next_c.pfd = (c.pfd == PFD_UP) ? PFD_IDLE : PFD_DOWN;
    end
    next_c.pc_oe  = (next_c.pfd != PFD_IDLE);
    next_c.pc_out = (next_c.pfd == PFD_UP);
    // Port drivers
    next_c.ded_oe = next_c.ctrl_a[F_DED +: 4];
    if (next_c.ctrl_a[F_TB]) begin
      next_c.ded_oe[0] = next_c.tb_level;
    end
    next_c.dual_oe = next_c.ctrl_a[F_DIR +: 2] & next_c.ctrl_a[F_DOUT +: 2];
    next_c.od_level = 1'b0;
    // Readback word frozen while enable is high
    if (!c.ce_s2) begin
      next_c.snap = content_word(c.ctrl_a[F_RSEL +: 3],
                                 c.dual_s2 & ~c.ctrl_a[F_DIR +: 2],
                                 c.if_result, c.if_busy, c.if_done);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign prdata            = c.prdata;
  assign pready            = c.pready;
  assign pslverr           = c.pslverr;
  assign serial_read_line  = l.dout;
  assign dedicated_out     = {4{c.od_level}};
  assign dedicated_oe      = c.ded_oe;
  assign dual_port_out     = {2{c.od_level}};
  assign dual_port_oe      = c.dual_oe;
  assign phase_compare_out = c.pc_out;
  assign phase_compare_oe  = c.pc_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] busy_len;
  logic [1:0]       busy_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len <= '0;
      busy_sel <= 2'd0;
    end else if (start) begin
      busy_len <= '0;
      busy_sel <= next_c.ctrl_a[F_GATE +: 2];
    end else if (c.if_busy) begin
      busy_len <= busy_len + CNT_W'(1);
    end
  end

  sequence s_apply;
    c.pending && !c.ce_s2 && c.tog_s2 == c.tog_seen && !c.pend_b;
  endsequence

  sequence s_last_bit;
    chip_enable && l.mode_valid && l.dbits == 5'd23 &&
    (l.mode == MODE_WRITE_A || l.mode == MODE_WRITE_B);
  endsequence

  a_ports_follow_word: assert property (@(posedge pclk) disable iff (!presetn)
    s_apply ##1 !c.ctrl_a[F_TB] |-> c.ded_oe == c.pend_word[F_DED +: 4])
    else $error("dedicated ports do not follow applied word");

  a_time_base_out: assert property (@(posedge pclk) disable iff (!presetn)
    c.ctrl_a[F_TB] && $changed(c.tb_level) && $stable(c.ctrl_a) |-> $changed(c.ded_oe[0]))
    else $error("time base not on first dedicated port");

  a_reset_open: assert property (@(posedge pclk) disable iff (!presetn)
    !c.applied |-> c.ded_oe == 4'h0 && c.dual_oe == 2'h0)
    else $error("ports driven before control data");

  a_dual_dir_out: assert property (@(posedge pclk) disable iff (!presetn)
    (c.dual_oe & ~c.ctrl_a[F_DIR +: 2]) == 2'h0)
    else $error("dual-use pin driven while input");

  a_phase_up: assert property (@(posedge pclk) disable iff (!presetn)
    c.pfd == PFD_IDLE && div_edge && !ref_edge |=> c.pc_oe && c.pc_out)
    else $error("phase output not high on fast divider");

  a_gate_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(c.if_busy) |-> busy_len == gate_cycles(busy_sel))
    else $error("IF gate length wrong");

  a_write_done: assert property (@(posedge serial_clock_in) disable iff (!presetn)
    s_last_bit |=> $changed(l.wr_toggle) && l.held_word[WORD_W-1] == $past(serial_write_line))
    else $error("24-bit write not captured");

  a_mode_latch: assert property (@(posedge serial_clock_in) disable iff (!presetn)
    chip_enable && !l.mode_valid && l.abits == 4'd8 |=>
      l.mode_valid && l.mode == decode_mode($past(l.addr)))
    else $error("mode not latched on first enabled clock");

  a_readback_msb: assert property (@(posedge serial_clock_in) disable iff (!presetn)
    chip_enable && l.mode_valid && l.mode == MODE_READ |=>
      serial_read_line == $past(l.rb_shift[WORD_W-1]))
    else $error("readback bit order wrong");

endmodule
